/* File: rtl/rtcp_pkg.sv */
// Purpose: constants and types shared by the rtc bus port and its byte store
// Assumes: 125 MHz system clock, one osc tick per 32.768 kHz crystal cycle
// Notes: constant list and bus phase type below
package rtcp_pkg;
  localparam int CLK_KHZ = 125000;
  localparam int STARTUP_MS = 200;
  localparam int STARTUP_CYCLES = STARTUP_MS * CLK_KHZ;
  localparam int START_W = 25;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 128;
  localparam int DIV_W = 15;
  localparam int SYNC_W = 12;
  localparam int SY_AS = 8;
  localparam int SY_DS = 9;
  localparam int SY_RW = 10;
  localparam int SY_CS = 11;
  localparam logic [6:0] REG_A = 7'h0a;
  localparam logic [6:0] REG_B = 7'h0b;
  localparam logic [6:0] REG_C = 7'h0c;
  localparam logic [6:0] REG_D = 7'h0d;
  localparam int A_RO_BIT = 7;
  localparam int B_SQUARE_WAVE_ENABLE = 3;
  localparam int B_UIE = 4;
  localparam int B_AIE = 5;
  localparam int B_PIE = 6;
  localparam int C_IRQF = 7;
  localparam logic [7:0] REG_A_RST = 8'h00;
  localparam logic [7:0] REG_B_RST = 8'h00;
  localparam logic [7:0] REG_D_VAL = 8'h80;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [3:0] RS_OFF = 4'h0;
  localparam logic [3:0] RS_ALIAS_MAX = 4'h2;
  localparam logic [3:0] TAP_ALIAS = 4'h5;
  localparam logic [3:0] TAP_BASE = 4'h2;
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_READ, PH_WRITE} rtcp_phase_t;
endpackage

/* File: rtl/rtcp_mem_if.sv */
// Purpose: port between the bus engine and the byte store
// Assumes: writes and reads are single-cycle requests
// Notes: read data appears one clock after the request
`timescale 1ns/1ps
interface rtcp_mem_if;
  logic we;
  logic re;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

/* File: rtl/rtcp_mem.sv */
// Purpose: 128-byte store behind the bus port
// Assumes: contents survive reset, as battery-backed storage would
// Notes: read data comes from a register
`timescale 1ns/1ps
module rtcp_mem (
  input wire logic clk_i, // system clock
  rtcp_mem_if.mem port    // request and data
);
  logic [rtcp_pkg::DATA_W-1:0] mem_reg [rtcp_pkg::MEM_DEPTH];
  logic [rtcp_pkg::DATA_W-1:0] rdata_reg;

  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem_reg[port.addr] <= port.wdata;
    end
    if (port.re) begin
      rdata_reg <= mem_reg[port.addr];
    end
  end

  assign port.rdata = rdata_reg;
endmodule

/* File: rtl/rtcp_top.sv */
// Purpose: multiplexed bus port, power gating and rate tap of the rtc
// Assumes: strobes arrive unsynchronised; osc_tick_i pulses at crystal rate
// Notes: registers a-d live here, every other byte in the store
`timescale 1ns/1ps
module rtcp_top #(
  parameter int STARTUP_CYCLES = rtcp_pkg::STARTUP_CYCLES
) (
  input wire logic clock_i,              // 125 MHz clock
  input wire logic rst_b_i,              // async reset, active low
  input wire logic power_good_i,         // supply above access threshold
  input wire logic osc_running_i,        // crystal oscillator runs
  input wire logic divider_reset_i,      // divider chain held in reset
  input wire logic osc_tick_i,           // one pulse per crystal cycle
  input wire logic alarm_event_i,        // alarm match pulse
  input wire logic update_event_i,       // update ended pulse
  input wire logic bus_style_select_i,   // 1 strobe/level, 0 split strobes
  input wire logic chip_sel_b_i,         // chip select, active low
  input wire logic address_latch_strobe_i, // address strobe
  input wire logic data_phase_strobe_i,  // data strobe or read strobe
  input wire logic read_write_i,         // read/write level or write strobe
  input wire logic [7:0] ad_i,           // shared lines, input side
  output logic [7:0] ad_o,               // shared lines, output side
  output logic ad_oe_o,                  // shared lines driven
  output logic square_wave_out_o,        // square wave level
  output logic square_wave_oe_o,         // square wave driven
  output logic irq_b_o,                  // interrupt level, active low
  output logic irq_oe_o                  // interrupt pin pulled low
);
  typedef struct packed {
    logic [rtcp_pkg::SYNC_W-1:0] sync1;
    logic [rtcp_pkg::SYNC_W-1:0] sync2;
    logic as_q;
    logic rd_q;
    logic wr_q;
    logic [rtcp_pkg::START_W-1:0] start_cnt;
    logic start_done;
    logic [rtcp_pkg::DIV_W-1:0] div;
    logic tap_q;
    logic [6:0] addr;
    logic addr_valid;
    logic sel;
    rtcp_pkg::rtcp_phase_t phase;
    logic [7:0] wbuf;
    logic rd_reg;
    logic [7:0] rd_val;
    logic [7:0] reg_a;
    logic [7:0] reg_b;
    logic [2:0] flags;
    logic [7:0] ad_out;
    logic ad_oe;
    logic square_wave_out;
    logic sqw_oe;
    logic irq_b;
    logic irq_oe;
    logic mem_we;
    logic mem_re;
    logic [6:0] mem_addr;
    logic [7:0] mem_wdata;
  } rtcp_state_t;

  localparam logic [rtcp_pkg::START_W-1:0] START_LAST =
    rtcp_pkg::START_W'(STARTUP_CYCLES - 1);

  rtcp_state_t s_reg;
  rtcp_state_t s_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;

  rtcp_mem_if mif ();

  rtcp_mem u_mem (
    .clk_i (clock_i),
    .port  (mif.mem)
  );

  assign mif.we = s_next.mem_we;
  assign mif.re = s_next.mem_re;
  assign mif.addr = s_next.mem_addr;
  assign mif.wdata = s_next.mem_wdata;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  logic as_l;
  logic ds_l;
  logic rw_l;
  logic cs_l;
  logic [7:0] ad_l;
  logic rd_act;
  logic wr_act;
  logic access_ok;
  logic [3:0] rs;
  logic [3:0] tap_idx;
  logic tap;
  logic [2:0] set_ev;
  logic [2:0] enables;
  logic irq_act;
  logic is_reg;
  logic [7:0] reg_rd;

  always_comb begin
    s_next = s_reg;
    // strobes and lines pass two flops before anything looks at them
    s_next.sync1 = {chip_sel_b_i, read_write_i, data_phase_strobe_i,
                    address_latch_strobe_i, ad_i};
    s_next.sync2 = s_reg.sync1;
    as_l = s_reg.sync2[rtcp_pkg::SY_AS];
    ds_l = s_reg.sync2[rtcp_pkg::SY_DS];
    rw_l = s_reg.sync2[rtcp_pkg::SY_RW];
    // forced inactive whenever the supply is low
    cs_l = ~s_reg.sync2[rtcp_pkg::SY_CS] & power_good_i;
    ad_l = s_reg.sync2[7:0];
    if (bus_style_select_i) begin
      rd_act = ds_l & rw_l;
      wr_act = ds_l & ~rw_l;
    end else begin
      rd_act = ~ds_l;
      wr_act = ~rw_l;
    end
    s_next.as_q = as_l;
    s_next.rd_q = rd_act;
    s_next.wr_q = wr_act;

    // start-up delay restarts on every supply dip
    if (!power_good_i) begin
      s_next.start_cnt = '0;
      s_next.start_done = 1'b0;
    end else if (!s_reg.start_done) begin
      if (s_reg.start_cnt == START_LAST) begin
        s_next.start_done = 1'b1;
      end else begin
        s_next.start_cnt = s_reg.start_cnt + 1'b1;
      end
    end
    access_ok = power_good_i & s_reg.start_done & osc_running_i
                & ~divider_reset_i;

    if (divider_reset_i) begin
      s_next.div = '0;
    end else if (osc_tick_i) begin
      s_next.div = s_reg.div + 1'b1;
    end
    rs = s_reg.reg_a[3:0];
    if (rs <= rtcp_pkg::RS_ALIAS_MAX) begin
      tap_idx = rs + rtcp_pkg::TAP_ALIAS;
    end else begin
      tap_idx = rs - rtcp_pkg::TAP_BASE;
    end
    tap = (rs != rtcp_pkg::RS_OFF) & s_reg.div[tap_idx];
    s_next.tap_q = tap;
    s_next.square_wave_out = tap & s_reg.reg_b[rtcp_pkg::B_SQUARE_WAVE_ENABLE] & power_good_i;
    s_next.sqw_oe = power_good_i;

    // one periodic event per output period, none with code zero
    set_ev = {s_reg.tap_q & ~tap, alarm_event_i, update_event_i};
    enables = {s_reg.reg_b[rtcp_pkg::B_PIE], s_reg.reg_b[rtcp_pkg::B_AIE],
               s_reg.reg_b[rtcp_pkg::B_UIE]};
    irq_act = |(s_reg.flags & enables);

    is_reg = (s_reg.addr >= rtcp_pkg::REG_A) && (s_reg.addr <= rtcp_pkg::REG_D);
    case (s_reg.addr)
      rtcp_pkg::REG_A: reg_rd = s_reg.reg_a;
      rtcp_pkg::REG_B: reg_rd = s_reg.reg_b;
      rtcp_pkg::REG_C: reg_rd = {irq_act, s_reg.flags, 4'h0};
      rtcp_pkg::REG_D: reg_rd = rtcp_pkg::REG_D_VAL;
      default: reg_rd = 8'h00;
    endcase

    s_next.mem_we = 1'b0;
    s_next.mem_re = 1'b0;
    s_next.mem_addr = s_reg.addr;
    s_next.mem_wdata = s_reg.wbuf;

    // a new address phase always drops the old address
    if (as_l & ~s_reg.as_q) begin
      s_next.addr_valid = 1'b0;
      s_next.ad_oe = 1'b0;
      s_next.phase = rtcp_pkg::PH_IDLE;
    end else begin
      case (s_reg.phase)
        rtcp_pkg::PH_IDLE: begin
          s_next.ad_oe = 1'b0;
          if (~as_l & s_reg.as_q) begin
            s_next.addr = ad_l[6:0];
            s_next.addr_valid = 1'b1;
            s_next.sel = cs_l & access_ok;
            s_next.phase = rtcp_pkg::PH_ADDR;
          end
        end
        rtcp_pkg::PH_ADDR: begin
          s_next.ad_oe = 1'b0;
          if (s_reg.sel & s_reg.addr_valid & cs_l & access_ok) begin
            if (rd_act & ~s_reg.rd_q) begin
              // bit six of the address reaches the upper ram half
              s_next.mem_re = 1'b1;
              s_next.rd_reg = is_reg;
              s_next.rd_val = reg_rd;
              if (s_reg.addr == rtcp_pkg::REG_C) begin
                s_next.flags = rtcp_pkg::FLAGS_RST;
              end
              s_next.phase = rtcp_pkg::PH_READ;
            end else if (wr_act & ~s_reg.wr_q) begin
              s_next.wbuf = ad_l;
              s_next.phase = rtcp_pkg::PH_WRITE;
            end
          end
        end
        rtcp_pkg::PH_READ: begin
          if (!rd_act || !access_ok) begin
            s_next.ad_oe = 1'b0;
            s_next.phase = rtcp_pkg::PH_ADDR;
          end else begin
            s_next.ad_out = s_reg.rd_reg ? s_reg.rd_val : mif.rdata;
            s_next.ad_oe = 1'b1;
          end
        end
        rtcp_pkg::PH_WRITE: begin
          s_next.ad_oe = 1'b0;
          if (!access_ok) begin
            s_next.phase = rtcp_pkg::PH_ADDR;
          end else if (wr_act) begin
            s_next.wbuf = ad_l;
          end else begin
            // commit what stood on the lines just before the trailing edge
            case (s_reg.addr)
              rtcp_pkg::REG_A: begin
                s_next.reg_a = s_reg.wbuf;
                s_next.reg_a[rtcp_pkg::A_RO_BIT] = 1'b0;
              end
              rtcp_pkg::REG_B: s_next.reg_b = s_reg.wbuf;
              rtcp_pkg::REG_C: s_next.reg_b = s_reg.reg_b;
              rtcp_pkg::REG_D: s_next.reg_b = s_reg.reg_b;
              default: s_next.mem_we = 1'b1;
            endcase
            s_next.phase = rtcp_pkg::PH_ADDR;
          end
        end
        default: begin
          s_next.ad_oe = 1'b0;
          s_next.phase = rtcp_pkg::PH_IDLE;
        end
      endcase
    end

    // events in the clearing cycle still land
    s_next.flags = s_next.flags | set_ev;

    if (!power_good_i) begin
      s_next.ad_oe = 1'b0;
      s_next.addr_valid = 1'b0;
      s_next.phase = rtcp_pkg::PH_IDLE;
    end
    // released pin floats to its pull-up level, so the level follows the drive
    s_next.irq_b = ~(irq_act & power_good_i);
    s_next.irq_oe = irq_act & power_good_i;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.phase <= rtcp_pkg::PH_IDLE;
      s_reg.reg_a <= rtcp_pkg::REG_A_RST;
      s_reg.reg_b <= rtcp_pkg::REG_B_RST;
      s_reg.flags <= rtcp_pkg::FLAGS_RST;
      s_reg.irq_b <= 1'b1;
      // idle pin levels: strobes low, chip select and write level high
      s_reg.sync1[rtcp_pkg::SY_CS] <= 1'b1;
      s_reg.sync1[rtcp_pkg::SY_RW] <= 1'b1;
      s_reg.sync2[rtcp_pkg::SY_CS] <= 1'b1;
      s_reg.sync2[rtcp_pkg::SY_RW] <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ad_o = s_reg.ad_out;
  assign ad_oe_o = s_reg.ad_oe;
  assign square_wave_out_o = s_reg.square_wave_out;
  assign square_wave_oe_o = s_reg.sqw_oe;
  assign irq_b_o = s_reg.irq_b;
  assign irq_oe_o = s_reg.irq_oe;
endmodule

/* File: bench/rtcp_top_assertions.sv */
// Purpose: port checks of the rtc bus port
// Assumes: STARTUP_CYCLES equals the value of the bound instance
// Notes: bind follows the module
`timescale 1ns/1ps
module rtcp_top_assertions #(
  parameter int STARTUP_CYCLES = 20
) (
  input wire logic clock_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic power_good_i, // supply ok
  input wire logic osc_running_i, // osc on
  input wire logic divider_reset_i, // divider held
  input wire logic bus_style_select_i, // style
  input wire logic chip_sel_b_i, // select
  input wire logic data_phase_strobe_i, // strobe
  input wire logic read_write_i, // level
  input wire logic ad_oe_o, // bus drive
  input wire logic square_wave_out_o, // wave
  input wire logic square_wave_oe_o, // wave drive
  input wire logic irq_b_o, // irq level
  input wire logic irq_oe_o // irq drive
);
  logic [31:0] up_reg;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // cycles of good supply since reset or the last dip, held at STARTUP_CYCLES
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_reg <= '0;
    end else if (!power_good_i) begin
      up_reg <= '0;
    end else if (up_reg < 32'(STARTUP_CYCLES)) begin
      up_reg <= up_reg + 32'h0000_0001;
    end
  end
  sequence s_rd1_on;
    (bus_style_select_i && !chip_sel_b_i && data_phase_strobe_i && read_write_i
      && power_good_i && osc_running_i && !divider_reset_i
      && up_reg >= 32'(STARTUP_CYCLES)) [*6];
  endsequence
  sequence s_rd1_over;
    (bus_style_select_i && !data_phase_strobe_i) [*5];
  endsequence
  sequence s_rd0_over;
    (!bus_style_select_i && data_phase_strobe_i) [*5];
  endsequence
  a_startup_hold: assert property (
    $rose(ad_oe_o) |-> up_reg >= 32'(STARTUP_CYCLES)) else $error("bus driven too early");
  a_lowpwr_quiet: assert property (
    (!power_good_i) [*5] |-> !ad_oe_o && !square_wave_oe_o && !irq_oe_o)
    else $error("output driven at low supply");
  a_sqw_lowpwr: assert property ((!power_good_i) [*5] |-> !square_wave_out_o)
    else $error("square wave at low supply");
  a_sqw_drive: assert property (power_good_i [*6] |-> square_wave_oe_o)
    else $error("square wave pin not driven");
  a_cs_refuse: assert property (chip_sel_b_i [*8] |-> !$rose(ad_oe_o))
    else $error("read without chip select");
  a_osc_refuse: assert property (
    (!osc_running_i || divider_reset_i) [*8] |-> !$rose(ad_oe_o))
    else $error("read while oscillator idle");
  a_rd1_answer: assert property (s_rd1_on |-> ad_oe_o)
    else $error("read byte not driven");
  a_rd1_release: assert property (s_rd1_over |-> !ad_oe_o)
    else $error("bus held after data strobe");
  a_rd0_release: assert property (s_rd0_over |-> !ad_oe_o)
    else $error("bus held after read strobe");
  a_wr_quiet: assert property (
    (bus_style_select_i && data_phase_strobe_i && !read_write_i) [*6] |-> !ad_oe_o)
    else $error("bus driven in write");
  a_irq_level: assert property (irq_oe_o == !irq_b_o)
    else $error("interrupt level and drive disagree");
endmodule
bind rtcp_top rtcp_top_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .power_good_i(power_good_i),
  .osc_running_i(osc_running_i), .divider_reset_i(divider_reset_i),
  .bus_style_select_i(bus_style_select_i), .chip_sel_b_i(chip_sel_b_i),
  .data_phase_strobe_i(data_phase_strobe_i), .read_write_i(read_write_i),
  .ad_oe_o(ad_oe_o), .square_wave_out_o(square_wave_out_o),
  .square_wave_oe_o(square_wave_oe_o), .irq_b_o(irq_b_o), .irq_oe_o(irq_oe_o)
);

/* File: bench/rtcp_host.sv */
// Purpose: bus master model on the muxed address/data lines
// Assumes: every strobe phase lasts at least 4 clocks
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module rtcp_host (
  input wire logic clock_i, // clock
  input wire logic [7:0] pin_i, // resolved lines
  input wire logic dev_oe_i, // device drives lines
  output logic style_o, // bus style
  output logic cs_b_o, // chip select
  output logic as_o, // address strobe
  output logic ds_o, // data or read strobe
  output logic rw_o, // level or write strobe
  output logic [7:0] ad_o // master side of lines
);
  initial begin
    style_o = 1'b1;
    cs_b_o = 1'b1;
    as_o = 1'b0;
    ds_o = 1'b0;
    rw_o = 1'b1;
    ad_o = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // idle strobe level moves with the style
  task automatic set_style(input logic s);
    style_o = s;
    ds_o = !s;
  endtask
  task automatic access(input logic wr, input logic cs_b, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic seen);
    seen = 1'b0;
    cs_b_o = cs_b;
    as_o = 1'b1;
    ad_o = {1'b0, a};
    hold(4);
    as_o = 1'b0;
    hold(4);
    ad_o = wr ? d : ~ad_o;
    if (style_o) begin
      rw_o = !wr;
      ds_o = 1'b1;
    end else if (wr) begin
      rw_o = 1'b0;
    end else begin
      ds_o = 1'b0;
    end
    repeat (8) begin
      @(posedge clock_i);
      seen = seen | dev_oe_i;
      q = pin_i;
    end
    #1;
    ds_o = !style_o;
    rw_o = 1'b1;
    hold(4);
    ad_o = ~ad_o;
    cs_b_o = 1'b1;
    // let an edge pass so a following request never reassigns in this step
    hold(1);
  endtask
endmodule

/* File: bench/rtcp_top_bench.sv */
// Purpose: self-checking bench of the rtc bus port and rate tap
// Assumes: one osc tick every second clock
// Notes: start-up delay shortened to SU clocks
`timescale 1ns/1ps
module rtcp_top_bench;
  localparam int SU = 20;
  logic clock_i = 1'b0;
  logic rst_b = 1'b0;
  logic pg = 1'b1;
  logic osc = 1'b1;
  logic divr = 1'b0;
  logic tick = 1'b0;
  logic alm = 1'b0;
  logic upd = 1'b0;
  logic style, cs_b, as_s, ds, rw, ad_oe, square_wave_out, sqw_oe, irq_b, irq_oe, seen;
  logic [7:0] host_ad, dut_ad, pin, q;
  int num_errors = 0;
  int num_checks = 0;
  assign pin = ad_oe ? dut_ad : host_ad;
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) tick <= #1 ~tick;
  rtcp_top #(.STARTUP_CYCLES(SU)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b), .power_good_i(pg), .osc_running_i(osc),
    .divider_reset_i(divr), .osc_tick_i(tick), .alarm_event_i(alm), .update_event_i(upd),
    .bus_style_select_i(style), .chip_sel_b_i(cs_b), .address_latch_strobe_i(as_s),
    .data_phase_strobe_i(ds), .read_write_i(rw), .ad_i(pin), .ad_o(dut_ad), .ad_oe_o(ad_oe),
    .square_wave_out_o(square_wave_out), .square_wave_oe_o(sqw_oe), .irq_b_o(irq_b), .irq_oe_o(irq_oe)
  );
  rtcp_host host (
    .clock_i(clock_i), .pin_i(pin), .dev_oe_i(ad_oe), .style_o(style), .cs_b_o(cs_b),
    .as_o(as_s), .ds_o(ds), .rw_o(rw), .ad_o(host_ad)
  );
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host.access(1'b0, 1'b0, a, 8'h00, q, seen);
    check(16'(q), 16'(e));
    check(16'(seen), 16'h0001);
  endtask
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
    host.access(1'b1, 1'b0, a, d, q, seen);
    rd(a, e);
  endtask
  // tap k toggles every 2^k ticks, a tick every second clock
  function automatic int half_per(input logic [3:0] c);
    return (c < 4'h3) ? (2 << (c + 4'h5)) : (2 << (c - 4'h2));
  endfunction
  task automatic edge_wait(input int lim, output int n);
    logic s;
    s = square_wave_out;
    n = 0;
    while (square_wave_out === s && n < lim) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  initial begin
    int n;
    int lim;
    logic [6:0] a;
    logic [7:0] d;
    void'($urandom(72417));
    repeat (12) @(posedge clock_i);
    #1;
    rst_b = 1'b1;
    repeat (SU + 10) @(posedge clock_i);
    #1;
    for (int i = 0; i < 24; i++) begin
      host.set_style(i[0]);
      a = 7'($urandom_range(127, 14));
      d = 8'($urandom);
      wr_rd(a, d, d);
    end
    host.set_style(1'b1);
    wr_rd(7'h05, 8'h3c, 8'h3c);
    wr_rd(7'h45, 8'hc3, 8'hc3);
    rd(7'h05, 8'h3c);
    wr_rd(rtcp_pkg::REG_D, 8'h00, rtcp_pkg::REG_D_VAL);
    wr_rd(7'h20, 8'h5a, 8'h5a);
    // refused cycles: no select, low supply, oscillator stopped, divider held
    for (int k = 0; k < 4; k++) begin
      pg = (k != 1);
      osc = (k != 2);
      divr = (k == 3);
      host.access(1'b1, k == 0, 7'h20, 8'h22, q, seen);
      host.access(1'b0, k == 0, 7'h20, 8'h00, q, seen);
      check(16'(seen), 16'h0000);
      pg = 1'b1;
      osc = 1'b1;
      divr = 1'b0;
      repeat (SU + 10) @(posedge clock_i);
      #1;
      rd(7'h20, 8'h5a);
    end
    // a supply dip restarts the start-up delay: a read right after it is refused
    pg = 1'b0;
    @(posedge clock_i);
    #1;
    pg = 1'b1;
    host.access(1'b0, 1'b0, 7'h20, 8'h00, q, seen);
    check(16'(seen), 16'h0000);
    repeat (SU + 10) @(posedge clock_i);
    #1;
    host.access(1'b0, 1'b0, rtcp_pkg::REG_C, 8'h00, q, seen);
    wr_rd(rtcp_pkg::REG_B, 8'h28, 8'h28);
    alm = 1'b1;
    upd = 1'b1;
    @(posedge clock_i);
    #1;
    alm = 1'b0;
    upd = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    check(16'(irq_oe), 16'h0001);
    rd(rtcp_pkg::REG_C, 8'hb0);
    check(16'(irq_oe), 16'h0000);
    rd(rtcp_pkg::REG_C, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr_rd(rtcp_pkg::REG_A, 8'(c), 8'(c));
      lim = (c == 0) ? 300 : 2 * half_per(4'(c)) + 8;
      edge_wait(lim, n);
      edge_wait(lim, n);
      check(16'(n), (c == 0) ? 16'(lim) : 16'(half_per(4'(c))));
      if (c != 0 && n >= lim) close_out();
    end
    wr_rd(rtcp_pkg::REG_A, 8'h03, 8'h03);
    wr_rd(rtcp_pkg::REG_B, 8'h20, 8'h20);
    edge_wait(300, n);
    edge_wait(300, n);
    check(16'(n), 16'h012c);
    check(16'(square_wave_out), 16'h0000);
    rd(rtcp_pkg::REG_C, 8'h40);
    close_out();
  end
endmodule
